/* File: bench/tpmr_bench.sv */
// self-checking bench of the micro ram
`timescale 1ns/1ps
module tpmr_bench import tpmr_pkg::*;;
   logic mclk;
   logic rst_n;
   tpmr_rd_ctl_s rd0_ctl;
   tpmr_rd_ctl_s rd1_ctl;
   tpmr_wr_ctl_s wr_ctl;
   tpmr_word_t rd0_data;
   tpmr_word_t rd1_data;
   logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, q;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic s_axi_rvalid, s_axi_rready;
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;
   logic [5:0] f0 [4] = '{6'h2F, 6'h37, 6'h3D, 6'h3E};
   logic [5:0] f1 [4] = '{6'h3D, 6'h2F, 6'h37, 6'h3E};

   tpmr_top u_tpmr_top (.mclk, .rst_n, .rd0_ctl, .rd1_ctl, .wr_ctl,
      .rd0_data, .rd1_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready);
   tpmr_fab u_tpmr_fab (.mclk, .rd0_ctl, .rd1_ctl, .wr_ctl);

   // free running clock
   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end
   // hang guard
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_errors++;
         stop_test();
      end
   end

   function automatic tpmr_addr_t ad(int i);
      return tpmr_addr_t'(21 * i);
   endfunction
   function automatic tpmr_word_t dv(int i);
      return 18'h2A5C3 + 18'h1111 * 18'(i);
   endfunction
   function automatic tpmr_rd_ctl_s cfg(tpmr_addr_t a, logic [5:0] f);
      return tpmr_rd_ctl_s'({a, 2'b11, f[5:3], 1'b0, f[2:0]});
   endfunction
   // address and output clocks rise together
   function automatic tpmr_rd_ctl_s cfg_early(tpmr_addr_t a);
      return tpmr_rd_ctl_s'({a, 2'b11, 3'b111, 1'b1, 3'b111});
   endfunction

   // one axi lite transfer, write or read
   task automatic axi(input bit w, input logic [31:0] a, d);
      @(posedge mclk);
      if (w) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         fork
            begin
               do @(posedge mclk); while (!s_axi_awready);
               s_axi_awvalid <= 1'b0;
            end
            begin
               do @(posedge mclk); while (!s_axi_wready);
               s_axi_wvalid <= 1'b0;
            end
         join
         do @(posedge mclk); while (!s_axi_bvalid);
         r = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         do @(posedge mclk); while (!s_axi_arready);
         s_axi_arvalid <= 1'b0;
         do @(posedge mclk); while (!s_axi_rvalid);
         q = s_axi_rdata;
         r = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask

   task automatic chk_word(string nm, tpmr_word_t e, tpmr_word_t s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask
   task automatic chk_reg(string nm, logic [31:0] e, logic [31:0] s);
      total_checks++;
      if (s !== e) begin
         n_errors++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, s);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      rst_n = 1'b0;
      {s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_awvalid} = '0;
      {s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (12) @(posedge mclk);
      rst_n <= 1'b1;
      for (int i = 0; i < 4; i++) begin
         u_tpmr_fab.wr(ad(i), dv(i), 2'b11);
      end
      u_tpmr_fab.wr(ad(0), ~dv(0), 2'b01);
      u_tpmr_fab.wr(ad(1), ~dv(1), 2'b10);
      for (int k = 0; k < 4; k++) begin
         u_tpmr_fab.rd(cfg(ad(k), 6'h3F), cfg(ad(k), 6'h3F));
         chk_word("rd0", dv(k), rd0_data);
         chk_word("rd1", dv(k), rd1_data);
         axi(1'b0, TPMR_STATUS_OFS, '0);
         chk_reg("status", {17'h0, 1'b1, ad(k), 2'b01, ad(k)}, q);
         u_tpmr_fab.rd(cfg(ad(k ^ 1), f0[k]), cfg(ad(k ^ 1), f1[k]));
         chk_word("rd0 clear", '0, rd0_data);
         chk_word("rd1 clear", '0, rd1_data);
      end
      u_tpmr_fab.rd(cfg(ad(1), 6'h3F), cfg(ad(2), 6'h3F));
      u_tpmr_fab.rd(cfg(ad(3), 6'h3B), cfg(ad(3), 6'h3B));
      chk_word("rd0 hold", dv(1), rd0_data);
      chk_word("rd1 hold", dv(2), rd1_data);
      u_tpmr_fab.rd(cfg(ad(0), 6'h1F), cfg(ad(0), 6'h1F));
      chk_word("rd0 keep", dv(3), rd0_data);
      chk_word("rd1 keep", dv(3), rd1_data);
      axi(1'b0, TPMR_CTRL_OFS, '0);
      chk_reg("ctrl reset", 32'h0, q);
      axi(1'b1, TPMR_CTRL_OFS, 32'h3);
      chk_reg("ctrl resp", {30'h0, TPMR_RESP_OKAY}, {30'h0, r});
      axi(1'b0, TPMR_CTRL_OFS, '0);
      chk_reg("ctrl", 32'h3, q);
      u_tpmr_fab.rd(cfg(ad(2), 6'h3F), cfg(ad(2), 6'h3F));
      chk_word("rd0 latch", dv(2), rd0_data);
      chk_word("rd1 latch", dv(2), rd1_data);
      // write without byte lane 0 leaves modes alone
      s_axi_wstrb <= 4'hE;
      axi(1'b1, TPMR_CTRL_OFS, 32'h0);
      axi(1'b0, TPMR_CTRL_OFS, '0);
      chk_reg("ctrl strobe", 32'h3, q);
      s_axi_wstrb <= 4'hF;
      // read0 latched, read1 edge: latch follows new address
      axi(1'b1, TPMR_CTRL_OFS, 32'h1);
      axi(1'b0, TPMR_CTRL_OFS, '0);
      chk_reg("ctrl one", 32'h1, q);
      u_tpmr_fab.rd(cfg_early(ad(1)), cfg_early(ad(1)));
      chk_word("rd0 latch follow", dv(1), rd0_data);
      chk_word("rd1 edge old", dv(2), rd1_data);
      axi(1'b1, TPMR_STATUS_OFS, 32'h0);
      chk_reg("status resp", {30'h0, TPMR_RESP_OKAY}, {30'h0, r});
      axi(1'b0, 32'h8, '0);
      chk_reg("unmapped", {30'h0, TPMR_RESP_SLVERR}, {30'h0, r});
      chk_reg("unmapped data", 32'h0, q);
      axi(1'b1, 32'h8, 32'h0);
      chk_reg("unmapped wr", {30'h0, TPMR_RESP_SLVERR}, {30'h0, r});
      stop_test();
   end
endmodule // tpmr_bench

/* File: bench/tpmr_chk_sva.sv */
// read port output checks of the micro ram
`timescale 1ns/1ps
module tpmr_chk
   import tpmr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire tpmr_rd_ctl_s rd0_ctl,
   input wire tpmr_rd_ctl_s rd1_ctl,
   input wire tpmr_word_t rd0_data,
   input wire tpmr_word_t rd1_data
);
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // enabled output clock rise per port
   sequence s_ld0;
      !rd0_ctl.out_clk ##1 rd0_ctl.out_clk && rd0_ctl.out_en;
   endsequence
   sequence s_ld1;
      !rd1_ctl.out_clk ##1 rd1_ctl.out_clk && rd1_ctl.out_en;
   endsequence
   AST_RD0_OUT_ACLR: assert property (
      !rd0_ctl.out_async_clear_n |-> rd0_data == '0)
      else $error("rd0 not cleared at once");
   AST_RD1_OUT_ACLR: assert property (
      !rd1_ctl.out_async_clear_n |-> rd1_data == '0)
      else $error("rd1 not cleared at once");
   AST_RD0_OUT_SCLR: assert property (
      s_ld0 ##0 !rd0_ctl.out_sync_clear_n ##1 rd0_ctl.out_async_clear_n
      |-> rd0_data == '0) else $error("rd0 sync clear missed");
   AST_RD1_OUT_SCLR: assert property (
      s_ld1 ##0 !rd1_ctl.out_sync_clear_n ##1 rd1_ctl.out_async_clear_n
      |-> rd1_data == '0) else $error("rd1 sync clear missed");
   AST_RD0_ADDR_ACLR: assert property (
      s_ld0 ##0 rd0_ctl.out_sync_clear_n && !rd0_ctl.address_async_clear_n
      ##1 rd0_ctl.out_async_clear_n |-> rd0_data == '0)
      else $error("rd0 address clear not seen");
   AST_RD1_ADDR_ACLR: assert property (
      s_ld1 ##0 rd1_ctl.out_sync_clear_n && !rd1_ctl.address_async_clear_n
      ##1 rd1_ctl.out_async_clear_n |-> rd1_data == '0)
      else $error("rd1 address clear not seen");
   AST_RD0_HOLD: assert property (
      rd0_ctl.out_async_clear_n && !rd0_ctl.out_en
      && rd0_ctl.out_sync_clear_n ##1 rd0_ctl.out_async_clear_n
      |-> $stable(rd0_data)) else $error("rd0 changed while disabled");
   AST_RD1_HOLD: assert property (
      rd1_ctl.out_async_clear_n && !rd1_ctl.out_en
      && rd1_ctl.out_sync_clear_n ##1 rd1_ctl.out_async_clear_n
      |-> $stable(rd1_data)) else $error("rd1 changed while disabled");
endmodule // tpmr_chk

bind tpmr_top tpmr_chk u_tpmr_chk (.mclk, .rst_n, .rd0_ctl, .rd1_ctl,
   .rd0_data, .rd1_data);

/* File: bench/tpmr_fab.sv */
// fabric logic model driving read and write ports
`timescale 1ns/1ps
module tpmr_fab
   import tpmr_pkg::*;
(
   input wire logic mclk,
   output tpmr_rd_ctl_s rd0_ctl,
   output tpmr_rd_ctl_s rd1_ctl,
   output tpmr_wr_ctl_s wr_ctl
);
   initial begin
      rd0_ctl = tpmr_rd_ctl_s'(15'h0077);
      rd1_ctl = tpmr_rd_ctl_s'(15'h0077);
      wr_ctl = '0;
   end
   task automatic wr(input tpmr_addr_t a, input tpmr_word_t d,
                     input logic [1:0] es);
      @(posedge mclk);
      wr_ctl <= {1'b0, a, d, es};
      @(posedge mclk);
      wr_ctl.clk <= 1'b1;
      @(posedge mclk);
      wr_ctl <= {1'b0, ~a, ~d, 2'b00};
   endtask
   task automatic rd(input tpmr_rd_ctl_s c0, input tpmr_rd_ctl_s c1);
      @(posedge mclk);
      rd0_ctl <= c0;
      rd1_ctl <= c1;
      @(posedge mclk);
      rd0_ctl.address_clk <= 1'b0;
      rd1_ctl.address_clk <= 1'b0;
      rd0_ctl.out_clk <= 1'b1;
      rd1_ctl.out_clk <= 1'b1;
      @(posedge mclk);
      rd0_ctl.out_clk <= 1'b0;
      rd1_ctl.out_clk <= 1'b0;
      rd0_ctl.address <= ~c0.address;
      rd1_ctl.address <= ~c1.address;
      #1;
   endtask
endmodule // tpmr_fab

/* File: core/tpmr_mem.sv */
// storage array with one write and two asynchronous read ports
`timescale 1ns/1ps
module tpmr_mem #(
   parameter int DEPTH = 64,
   parameter int WIDTH = 18,
   parameter int AW = 6
) (
   input wire logic mclk,
   input wire logic wr_strobe,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [AW-1:0] rd0_addr,
   output logic [WIDTH-1:0] rd0_data,
   input wire logic [AW-1:0] rd1_addr,
   output logic [WIDTH-1:0] rd1_data
);

   logic [WIDTH-1:0] mem [DEPTH];

   always_ff @(posedge mclk) begin
      if (wr_strobe) begin
         mem[wr_addr] <= wr_data;
      end
   end

   assign rd0_data = mem[rd0_addr];
   assign rd1_data = mem[rd1_addr];

endmodule // tpmr_mem

/* File: core/tpmr_pkg.sv */
// shared constants and carrier types of the three-port micro ram
package tpmr_pkg;

   // memory geometry
   localparam int TPMR_DEPTH = 64;
   localparam int TPMR_WIDTH = 18;
   localparam int TPMR_AW = 6;
   localparam int TPMR_NRD = 2;

   // register byte addresses
   localparam logic [31:0] TPMR_CTRL_OFS = 32'h0000_0000;
   localparam logic [31:0] TPMR_STATUS_OFS = 32'h0000_0004;

   // control register fields and reset value
   localparam int TPMR_CTRL_LAT_LSB = 0;
   localparam logic [1:0] TPMR_CTRL_RST = 2'h0;

   // status register fields
   localparam int TPMR_STAT_RD0_ADDR_LSB = 0;
   localparam int TPMR_STAT_RD0_SEL_BIT = 6;
   localparam int TPMR_STAT_RD1_ADDR_LSB = 8;
   localparam int TPMR_STAT_RD1_SEL_BIT = 14;

   // axi response codes
   localparam logic [1:0] TPMR_RESP_OKAY = 2'h0;
   localparam logic [1:0] TPMR_RESP_SLVERR = 2'h2;

   typedef logic [TPMR_AW-1:0] tpmr_addr_t;
   typedef logic [TPMR_WIDTH-1:0] tpmr_word_t;

   // register decode result
   typedef enum logic [1:0] {
      TPMR_REG_CTRL,
      TPMR_REG_STATUS,
      TPMR_REG_NONE
   } tpmr_reg_e;

   // one read port's control inputs
   typedef struct packed {
      tpmr_addr_t address;
      logic select;
      logic address_clk;
      logic address_en;
      logic address_sync_clear_n;
      logic address_async_clear_n;
      logic out_clk;
      logic out_en;
      logic out_sync_clear_n;
      logic out_async_clear_n;
   } tpmr_rd_ctl_s;

   // write port inputs
   typedef struct packed {
      logic clk;
      tpmr_addr_t address;
      tpmr_word_t data;
      logic enable;
      logic select;
   } tpmr_wr_ctl_s;

endpackage

/* File: core/tpmr_top.sv */
// three-port micro ram: two pipelined read ports, one write port
// Operation
// - both reads of one word stay correct
// - read0 during write: write ok, data undefined
// - read1 during write: write ok, data undefined
// - all three collide: write ok, reads undefined
// - read0 address latched on its address clock
// - read0 output loads on its output clock
// - read0 output async clear acts at once
// - read0 output loads only when enabled
// - read0 output sync clear on clock edge
// - read0 address loads only when enabled
// - read0 address sync clear on clock edge
// - read0 address async clear acts at once
// - read1 mirrors read0 with own signals
// - write needs enable and select at edge
// - writes only via write port, one cycle
// - address clear zeroes address and output
// - latch mode: output transparent while clock high
`timescale 1ns/1ps
module tpmr_top
   import tpmr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire tpmr_rd_ctl_s rd0_ctl,
   input wire tpmr_rd_ctl_s rd1_ctl,
   input wire tpmr_wr_ctl_s wr_ctl,
   output tpmr_word_t rd0_data,
   output tpmr_word_t rd1_data,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // whole module state
   typedef struct packed {
      logic [TPMR_NRD-1:0] latch;
      tpmr_addr_t [TPMR_NRD-1:0] addr;
      logic [TPMR_NRD-1:0] sel;
      tpmr_word_t [TPMR_NRD-1:0] dout;
      logic [TPMR_NRD-1:0] addr_clk_prev;
      logic [TPMR_NRD-1:0] out_clk_prev;
      logic wr_clk_prev;
      logic aw_got;
      logic w_got;
      logic [31:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } tpmr_state_s;

   tpmr_state_s q;
   tpmr_state_s d;

   tpmr_rd_ctl_s [TPMR_NRD-1:0] rd;
   tpmr_addr_t [TPMR_NRD-1:0] eff_addr;
   logic [TPMR_NRD-1:0] eff_sel;
   tpmr_word_t [TPMR_NRD-1:0] mem_word;
   tpmr_word_t [TPMR_NRD-1:0] rd_word;
   logic wr_strobe;
   logic [31:0] status_word;
   logic aw_take;
   logic w_take;
   logic ar_take;

   // register decode shared by read and write
   function automatic tpmr_reg_e reg_decode(input logic [31:0] a);
      logic [31:0] w;
      w = {a[31:2], 2'b00};
      if (w == TPMR_CTRL_OFS) begin
         return TPMR_REG_CTRL;
      end else if (w == TPMR_STATUS_OFS) begin
         return TPMR_REG_STATUS;
      end else begin
         return TPMR_REG_NONE;
      end
   endfunction

   assign rd = {rd1_ctl, rd0_ctl};

   // per-port address path and gated output
   genvar g;
   generate
      for (g = 0; g < TPMR_NRD; g++) begin : g_port
         // async clear masks address at once
         assign eff_addr[g] = rd[g].address_async_clear_n ? q.addr[g] : '0;
         assign eff_sel[g] = rd[g].address_async_clear_n & q.sel[g];
         assign rd_word[g] = eff_sel[g] ? mem_word[g] : '0;
      end
   endgenerate

   // write on edge with enable and select
   assign wr_strobe = wr_ctl.clk & ~q.wr_clk_prev & wr_ctl.enable &
      wr_ctl.select;

   tpmr_mem #(
      .DEPTH(TPMR_DEPTH),
      .WIDTH(TPMR_WIDTH),
      .AW(TPMR_AW)
   ) u_mem (
      .mclk(mclk),
      .wr_strobe(wr_strobe),
      .wr_addr(wr_ctl.address),
      .wr_data(wr_ctl.data),
      .rd0_addr(eff_addr[0]),
      .rd0_data(mem_word[0]),
      .rd1_addr(eff_addr[1]),
      .rd1_data(mem_word[1])
   );

   // output async clear acts without an edge
   assign rd0_data = rd[0].out_async_clear_n ? q.dout[0] : '0;
   assign rd1_data = rd[1].out_async_clear_n ? q.dout[1] : '0;

   // status word shows live address registers
   always_comb begin
      status_word = '0;
      status_word[TPMR_STAT_RD0_ADDR_LSB +: TPMR_AW] = eff_addr[0];
      status_word[TPMR_STAT_RD0_SEL_BIT] = eff_sel[0];
      status_word[TPMR_STAT_RD1_ADDR_LSB +: TPMR_AW] = eff_addr[1];
      status_word[TPMR_STAT_RD1_SEL_BIT] = eff_sel[1];
   end

   // bus handshakes
   assign s_axi_awready = ~q.aw_got & ~q.bvalid;
   assign s_axi_wready = ~q.w_got & ~q.bvalid;
   assign s_axi_arready = ~q.rvalid;
   assign aw_take = s_axi_awvalid & s_axi_awready;
   assign w_take = s_axi_wvalid & s_axi_wready;
   assign ar_take = s_axi_arvalid & s_axi_arready;
   assign s_axi_bvalid = q.bvalid;
   assign s_axi_bresp = q.bresp;
   assign s_axi_rvalid = q.rvalid;
   assign s_axi_rdata = q.rdata;
   assign s_axi_rresp = q.rresp;

   // next state of read ports and bus slave
   always_comb begin
      logic addr_edge;
      logic out_edge;
      logic out_load;
      addr_edge = 1'b0;
      out_edge = 1'b0;
      out_load = 1'b0;
      d = q;
      d.wr_clk_prev = wr_ctl.clk;
      // same structure for each read port
      for (int p = 0; p < TPMR_NRD; p++) begin
         addr_edge = rd[p].address_clk & ~q.addr_clk_prev[p];
         out_edge = rd[p].out_clk & ~q.out_clk_prev[p];
         d.addr_clk_prev[p] = rd[p].address_clk;
         d.out_clk_prev[p] = rd[p].out_clk;
         // async clear holds the register at zero
         if (!rd[p].address_async_clear_n) begin
            d.addr[p] = '0;
            d.sel[p] = 1'b0;
         end else if (addr_edge) begin
            // sync clear on the address edge
            if (!rd[p].address_sync_clear_n) begin
               d.addr[p] = '0;
               d.sel[p] = 1'b0;
            end else if (rd[p].address_en) begin
               d.addr[p] = rd[p].address;
               d.sel[p] = rd[p].select;
            end
         end
         // latch follows while output clock high
         // otherwise loads on output clock edge
         out_load = q.latch[p] ? rd[p].out_clk : out_edge;
         if (!rd[p].out_async_clear_n) begin
            d.dout[p] = '0;
         end else if (out_load) begin
            // sync clear whenever the output loads
            if (!rd[p].out_sync_clear_n) begin
               d.dout[p] = '0;
            end else if (rd[p].out_en) begin
               // colliding read may take old word
               d.dout[p] = rd_word[p];
            end
         end
      end
      // write address and data, either order
      if (aw_take) begin
         d.aw_got = 1'b1;
         d.awaddr = s_axi_awaddr;
      end
      if (w_take) begin
         d.w_got = 1'b1;
         d.wdata = s_axi_wdata;
         d.wstrb = s_axi_wstrb;
      end
      // write response once both halves are in
      if (q.aw_got && q.w_got && !q.bvalid) begin
         d.aw_got = 1'b0;
         d.w_got = 1'b0;
         d.bvalid = 1'b1;
         d.bresp = TPMR_RESP_OKAY;
         case (reg_decode(q.awaddr))
            TPMR_REG_CTRL: begin
               if (q.wstrb[0]) begin
                  d.latch = q.wdata[TPMR_CTRL_LAT_LSB +: TPMR_NRD];
               end
            end
            TPMR_REG_STATUS: begin
               d.bresp = TPMR_RESP_OKAY;
            end
            default: begin
               d.bresp = TPMR_RESP_SLVERR;
            end
         endcase
      end else if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // read channel
      if (ar_take) begin
         d.rvalid = 1'b1;
         d.rresp = TPMR_RESP_OKAY;
         d.rdata = '0;
         case (reg_decode(s_axi_araddr))
            TPMR_REG_CTRL: begin
               d.rdata[TPMR_CTRL_LAT_LSB +: TPMR_NRD] = q.latch;
            end
            TPMR_REG_STATUS: begin
               d.rdata = status_word;
            end
            default: begin
               d.rresp = TPMR_RESP_SLVERR;
            end
         endcase
      end else if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
   end

   // state register with synchronous reset
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         q <= '0;
         q.latch <= TPMR_CTRL_RST;
      end else begin
         q <= d;
      end
   end

endmodule // tpmr_top
